// *** twb_ctrl.sv ***
// tape word buffer controller with memory request, role select and word counter
// Contract
// - two input and two output one-word buffers, memory and tape sides alternate
// - request flag asks dispatcher; grant acknowledge clears it
// - word end sets request via write gate or read gate; read gate off in check-read
// - write start sets request from first load pulse then second load pulse
// - no write request on word end when continue low, tenth word moved and count ten
// - word end with request still set gives overflow pulse and sticky flag
// - role select toggles each word end; write start controls override
// - write: role set loads odd from memory, tape writes even; clear swaps
// - first load pulse clears role select, second load pulse sets it
// - read: role set sends odd to memory, tape fills even; clear swaps
// - counter clear pulse sets role select
// - word counter is a closed ten state counter
// - write preloads step counter ten to one, then one to two
// - last two write word ends start no transfer, count rests at ten
// - read ends with counter reaching ten on the last transfer
// - check-read: word end steps the counter one microsecond later
// - five flip-flop code, decodes for counts one to three, seven to ten
// - counter clears to zero code meaning ten, then counts upward and wraps
// - check bit toggles each step, step decoder advances the data bits
// - even total of ones raises parity error and sets counter flag
// - parity checker disabled while circuits are available
// - word end is one pulse every twelfth digit step
// - circuits available cleared at operation start, set at end
`timescale 1ns/1ps
module twb_ctrl
    import twb_pkg::*;
#(
    parameter int unsigned WORD_W = 48
)
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                op_start_pulse,
    input  wire logic                op_end_pulse,
    input  wire logic                write_circuits_in_use,
    input  wire logic                read_circuits_in_use,
    input  wire logic                check_read_mode,
    input  wire logic                digit_step_pulse,
    input  wire logic                first_word_load_pulse,
    input  wire logic                second_word_load_pulse,
    input  wire logic                continue_flag,
    input  wire logic                tenth_word_transferred,
    input  wire logic                counter_clear_pulse,
    input  wire logic                memory_grant_ack,
    input  wire logic                memory_transfer_strobe,
    input  wire logic                diag_clear,
    input  wire logic                tape_in_strobe,
    input  wire logic [WORD_W-1:0]   tape_in_data,
    input  wire logic                mem_out_strobe,
    input  wire logic [WORD_W-1:0]   mem_out_data,
    output logic                     memory_request,
    output logic                     role_select,
    output logic                     word_end_pulse,
    output logic                     overflow_error_pulse,
    output logic                     overflow_diag,
    output logic                     word_count_parity_error,
    output logic                     word_counter_diag,
    output logic                     circuits_available,
    output logic [WC_DEC_W-1:0]      word_count_decode,
    output logic                     count_one_decode,
    output logic                     count_ten_decode,
    output logic [WORD_W-1:0]        mem_in_data,
    output logic [WORD_W-1:0]        tape_out_data,
    output twb_phase_e               write_phase
);

    // cycles left to the delayed step after the eight quiet cycles of cr_step_a
    localparam int CR_LAG = int'(CR_STEP_CYC) - 8;

    twb_wc_if wc ();

    logic                mreq_reg;
    logic                role_reg;
    logic                ovf_pulse_reg;
    logic                ovf_diag_reg;
    logic                wc_diag_reg;
    logic                avail_reg;
    logic [CR_DLY_W-1:0] dly_reg;
    logic [WORD_W-1:0]   in_buf_reg  [2];
    logic [WORD_W-1:0]   out_buf_reg [2];
    logic [WORD_W-1:0]   mem_in_reg;
    logic [WORD_W-1:0]   tape_out_reg;
    twb_phase_e          phase_reg;
    twb_phase_e          phase_next;

    logic                wend;
    logic                end_block;
    logic                set_write;
    logic                set_read;
    logic                mreq_set;
    logic                start_ctl;
    logic                cr_step;

    twb_word_counter u_word_counter (
        .clk (clk),
        .rst (rst),
        .wc  (wc.cnt)
    );

    twb_word_end_gen u_word_end_gen (
        .clk (clk),
        .rst (rst),
        .wc  (wc.we)
    );

    assign wend = wc.word_end;

    // word end gating of the memory request
    assign end_block = !continue_flag && tenth_word_transferred && wc.dec[DEC_10];
    assign set_write = wend && write_circuits_in_use && !end_block;
    assign set_read  = wend && read_circuits_in_use && !check_read_mode;
    assign mreq_set  = set_write || set_read || first_word_load_pulse || second_word_load_pulse;
    assign start_ctl = first_word_load_pulse || second_word_load_pulse;

    // set wins over the grant acknowledge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mreq_reg <= 1'b0;
        end else if (mreq_set) begin
            mreq_reg <= 1'b1;
        end else if (memory_grant_ack) begin
            mreq_reg <= 1'b0;
        end
    end

    // overflow check at every word end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovf_pulse_reg <= 1'b0;
        end else begin
            ovf_pulse_reg <= wend && mreq_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovf_diag_reg <= 1'b0;
        end else if (wend && mreq_reg) begin
            ovf_diag_reg <= 1'b1;
        end else if (diag_clear) begin
            ovf_diag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wc_diag_reg <= 1'b0;
        end else if (wc.par_err) begin
            wc_diag_reg <= 1'b1;
        end else if (diag_clear) begin
            wc_diag_reg <= 1'b0;
        end
    end

    // role select: start controls override the toggle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            role_reg <= ROLE_RST;
        end else if (counter_clear_pulse) begin
            role_reg <= 1'b1;
        end else if (first_word_load_pulse) begin
            role_reg <= 1'b0;
        end else if (second_word_load_pulse) begin
            role_reg <= 1'b1;
        end else if (wend) begin
            role_reg <= !role_reg;
        end
    end

    // circuits available, start wins over end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avail_reg <= AVAIL_RST;
        end else if (op_start_pulse) begin
            avail_reg <= 1'b0;
        end else if (op_end_pulse) begin
            avail_reg <= 1'b1;
        end
    end

    // check-read step delayed after the word end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dly_reg <= '0;
        end else if (counter_clear_pulse) begin
            dly_reg <= '0;
        end else if (wend && check_read_mode) begin
            dly_reg <= CR_DLY_W'(CR_STEP_CYC);
        end else if (dly_reg != '0) begin
            dly_reg <= dly_reg - CR_DLY_W'(1);
        end
    end

    assign cr_step = (dly_reg == CR_DLY_W'(1));

    assign wc.step       = (memory_transfer_strobe && !check_read_mode) || cr_step;
    assign wc.clear      = counter_clear_pulse;
    assign wc.operating  = !avail_reg;
    assign wc.digit_step = digit_step_pulse;

    // buffer pairs: index 1 is odd, memory side uses role, tape side the other
    for (genvar i = 0; i < 2; i++) begin : g_buf
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                in_buf_reg[i] <= '0;
            end else if (tape_in_strobe && (role_reg != 1'(i))) begin
                in_buf_reg[i] <= tape_in_data;
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                out_buf_reg[i] <= '0;
            end else if (mem_out_strobe && (role_reg == 1'(i))) begin
                out_buf_reg[i] <= mem_out_data;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_in_reg   <= '0;
            tape_out_reg <= '0;
        end else begin
            mem_in_reg   <= in_buf_reg[role_reg];
            tape_out_reg <= out_buf_reg[!role_reg];
        end
    end

    // write start phase tracking
    always_comb begin
        phase_next = phase_reg;
        unique case (phase_reg)
            TWB_IDLE: if (first_word_load_pulse) phase_next = TWB_PRE1;
            TWB_PRE1: if (second_word_load_pulse) phase_next = TWB_PRE2;
            TWB_PRE2: if (wend) phase_next = TWB_RUN;
            TWB_RUN:  if (op_end_pulse) phase_next = TWB_IDLE;
        endcase
        if (counter_clear_pulse) begin
            phase_next = TWB_IDLE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_reg <= TWB_IDLE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    assign memory_request          = mreq_reg;
    assign role_select             = role_reg;
    assign word_end_pulse          = wc.word_end;
    assign overflow_error_pulse    = ovf_pulse_reg;
    assign overflow_diag           = ovf_diag_reg;
    assign word_count_parity_error = wc.par_err;
    assign word_counter_diag       = wc_diag_reg;
    assign circuits_available      = avail_reg;
    assign word_count_decode       = wc.dec;
    assign count_one_decode        = wc.dec[DEC_1];
    assign count_ten_decode        = wc.dec[DEC_10];
    assign mem_in_data             = mem_in_reg;
    assign tape_out_data           = tape_out_reg;
    assign write_phase             = phase_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    load_req_a: assert property (first_word_load_pulse |=> memory_request)
        else $error("first load pulse did not raise request");
    grant_clr_a: assert property (memory_grant_ack && !mreq_set |=> !memory_request)
        else $error("grant did not clear request");
    write_gate_a: assert property (wend && write_circuits_in_use && !end_block |=> memory_request)
        else $error("write word end did not set request");
    check_block_a: assert property (wend && check_read_mode && !write_circuits_in_use && !start_ctl
        && !mreq_reg |=> !memory_request)
        else $error("check-read word end set request");
    write_end_a: assert property (wend && end_block && !read_circuits_in_use && !start_ctl
        && !mreq_reg |=> !memory_request)
        else $error("final write word end set request");
    overflow_a: assert property (wend && memory_request |=> overflow_error_pulse && overflow_diag)
        else $error("overflow not flagged");
    role_tog_a: assert property (wend && !counter_clear_pulse && !start_ctl
        |=> role_select != $past(role_select))
        else $error("role select did not toggle");
    first_role_a: assert property (first_word_load_pulse && !counter_clear_pulse |=> !role_select)
        else $error("first load pulse did not clear role select");
    second_role_a: assert property (second_word_load_pulse && !first_word_load_pulse
        && !counter_clear_pulse |=> role_select)
        else $error("second load pulse did not set role select");
    clear_role_a: assert property (counter_clear_pulse |=> role_select)
        else $error("counter clear did not set role select");
    cr_step_a: assert property (wend && check_read_mode && !counter_clear_pulse
        ##1 (!wend && !counter_clear_pulse)[*8] |-> ##CR_LAG wc.step)
        else $error("check-read step not one microsecond after word end");
    avail_a: assert property (op_start_pulse |=> !circuits_available)
        else $error("circuits still available after start");
    end_avail_a: assert property (op_end_pulse && !op_start_pulse |=> circuits_available)
        else $error("circuits not available after end");

    // buffer routing, counter stepping and flag upkeep
    no_ovf_a: assert property (wend && !memory_request |=> !overflow_error_pulse)
        else $error("overflow without pending request");
    ovf_clr_a: assert property (diag_clear && !wend
        |=> !overflow_diag)
        else $error("overflow flag not cleared");
    out_load_a: assert property (mem_out_strobe
        |=> out_buf_reg[$past(role_reg)] == $past(mem_out_data))
        else $error("memory word in wrong output buffer");
    in_load_a: assert property (tape_in_strobe
        |=> in_buf_reg[!$past(role_reg)] == $past(tape_in_data))
        else $error("tape word in wrong input buffer");
    read_gate_a: assert property (wend && read_circuits_in_use && !check_read_mode |=> memory_request)
        else $error("read word end did not set request");
    second_req_a: assert property (second_word_load_pulse |=> memory_request)
        else $error("second load pulse did not raise request");
    first_step_a: assert property (memory_transfer_strobe && !check_read_mode && !counter_clear_pulse
        && count_ten_decode |=> count_one_decode)
        else $error("step from ten did not reach one");
    wrap_ten_a: assert property (memory_transfer_strobe && !check_read_mode && !counter_clear_pulse
        && word_count_decode[DEC_9] |=> count_ten_decode)
        else $error("step from nine did not wrap to ten");
    cr_hold_a: assert property (check_read_mode && !cr_step && !counter_clear_pulse
        |=> $stable(word_count_decode))
        else $error("check-read count moved early");
    wc_diag_a: assert property (word_count_parity_error |=> word_counter_diag)
        else $error("parity error not flagged");
    we_pulse_a: assert property (word_end_pulse |=> !word_end_pulse)
        else $error("word end longer than one cycle");

    preload_c: cover property (first_word_load_pulse ##[1:50] second_word_load_pulse);
    overflow_c: cover property (overflow_error_pulse);
    cr_step_c: cover property (check_read_mode && cr_step);
    write_end_c: cover property (wend && end_block);
    read_req_c: cover property (set_read);

endmodule // twb_ctrl

// *** twb_pkg.sv ***
// shared constants for the tape word buffer and word counter
package twb_pkg;

    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned CR_STEP_DELAY_NS = 1000;
    localparam int unsigned CR_STEP_CYC      = (CR_STEP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CR_DLY_W         = $clog2(CR_STEP_CYC + 1);

    localparam int unsigned DIGITS_PER_WORD  = 12;
    localparam int unsigned DIGIT_CNT_W      = 4;
    localparam logic [3:0]  DIGIT_LAST       = 4'hb;

    // counter data codes, check bit alternates so total ones stay odd
    localparam logic [3:0]  WC_CODE_TEN      = 4'h0;
    localparam logic [3:0]  WC_CODE_1        = 4'h1;
    localparam logic [3:0]  WC_CODE_2        = 4'h3;
    localparam logic [3:0]  WC_CODE_3        = 4'h2;
    localparam logic [3:0]  WC_CODE_4        = 4'h6;
    localparam logic [3:0]  WC_CODE_5        = 4'h7;
    localparam logic [3:0]  WC_CODE_6        = 4'h5;
    localparam logic [3:0]  WC_CODE_7        = 4'h4;
    localparam logic [3:0]  WC_CODE_8        = 4'hc;
    localparam logic [3:0]  WC_CODE_9        = 4'hd;
    localparam logic        WC_CHECK_CLEAR   = 1'b1;

    // word count decode bit positions
    localparam int unsigned WC_DEC_W         = 7;
    localparam int unsigned DEC_1            = 0;
    localparam int unsigned DEC_2            = 1;
    localparam int unsigned DEC_3            = 2;
    localparam int unsigned DEC_7            = 3;
    localparam int unsigned DEC_8            = 4;
    localparam int unsigned DEC_9            = 5;
    localparam int unsigned DEC_10           = 6;
    localparam logic [6:0]  WC_DEC_RST       = 7'h40;

    localparam logic        ROLE_RST         = 1'b1;
    localparam logic        AVAIL_RST        = 1'b1;

    typedef enum logic [1:0] {
        TWB_IDLE = 2'b00,
        TWB_PRE1 = 2'b01,
        TWB_PRE2 = 2'b10,
        TWB_RUN  = 2'b11
    } twb_phase_e;

endpackage

// *** twb_wc_if.sv ***
// carrier between the controller, the word counter and the word end generator
`timescale 1ns/1ps
interface twb_wc_if;
    logic                         step;
    logic                         clear;
    logic                         operating;
    logic                         digit_step;
    logic                         word_end;
    logic [twb_pkg::WC_DEC_W-1:0] dec;
    logic                         par_err;

    modport ctl (output step, clear, operating, digit_step, input word_end, dec, par_err);
    modport cnt (input step, clear, operating, output dec, par_err);
    modport we  (input digit_step, clear, output word_end);
endinterface

// *** twb_word_end_gen.sv ***
// word end pulse on every twelfth digit step
`timescale 1ns/1ps
module twb_word_end_gen
    import twb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    twb_wc_if.we     wc
);
    logic [DIGIT_CNT_W-1:0] digit_reg;
    logic                   word_end_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            digit_reg <= '0;
        end else if (wc.clear) begin
            digit_reg <= '0;
        end else if (wc.digit_step) begin
            digit_reg <= (digit_reg == DIGIT_LAST) ? '0 : digit_reg + 4'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_end_reg <= 1'b0;
        end else begin
            word_end_reg <= wc.digit_step && !wc.clear && (digit_reg == DIGIT_LAST);
        end
    end

    assign wc.word_end = word_end_reg;

endmodule // twb_word_end_gen

// *** twb_word_counter.sv ***
// ten state self checking word counter
`timescale 1ns/1ps
module twb_word_counter
    import twb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    twb_wc_if.cnt    wc
);
    logic [3:0]          data_reg;
    logic [3:0]          data_next;
    logic [3:0]          data_new;
    logic                check_bit_flop_reg;
    logic                check_new;
    logic [WC_DEC_W-1:0] dec_reg;
    logic                par_reg;

    always_comb begin
        unique case (data_reg)
            WC_CODE_TEN: data_next = WC_CODE_1;
            WC_CODE_1:   data_next = WC_CODE_2;
            WC_CODE_2:   data_next = WC_CODE_3;
            WC_CODE_3:   data_next = WC_CODE_4;
            WC_CODE_4:   data_next = WC_CODE_5;
            WC_CODE_5:   data_next = WC_CODE_6;
            WC_CODE_6:   data_next = WC_CODE_7;
            WC_CODE_7:   data_next = WC_CODE_8;
            WC_CODE_8:   data_next = WC_CODE_9;
            WC_CODE_9:   data_next = WC_CODE_TEN;
            default:     data_next = WC_CODE_TEN;
        endcase
    end

    assign data_new  = wc.clear ? WC_CODE_TEN : (wc.step ? data_next : data_reg);
    assign check_new = wc.clear ? WC_CHECK_CLEAR : (check_bit_flop_reg ^ wc.step);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_reg           <= WC_CODE_TEN;
            check_bit_flop_reg <= WC_CHECK_CLEAR;
        end else begin
            data_reg           <= data_new;
            check_bit_flop_reg <= check_new;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dec_reg <= WC_DEC_RST;
            par_reg <= 1'b0;
        end else begin
            dec_reg[DEC_1]  <= (data_new == WC_CODE_1);
            dec_reg[DEC_2]  <= (data_new == WC_CODE_2);
            dec_reg[DEC_3]  <= (data_new == WC_CODE_3);
            dec_reg[DEC_7]  <= (data_new == WC_CODE_7);
            dec_reg[DEC_8]  <= (data_new == WC_CODE_8);
            dec_reg[DEC_9]  <= (data_new == WC_CODE_9);
            dec_reg[DEC_10] <= (data_new == WC_CODE_TEN);
            par_reg         <= wc.operating && !(^{data_new, check_new});
        end
    end

    assign wc.dec     = dec_reg;
    assign wc.par_err = par_reg;

    clear_ten_a: assert property (@(posedge clk) disable iff (rst) wc.clear |=> wc.dec[DEC_10])
        else $error("counter clear did not decode ten");
    idle_parity_a: assert property (@(posedge clk) disable iff (rst) !wc.operating |=> !wc.par_err)
        else $error("parity error raised while idle");
    check_toggle_a: assert property (@(posedge clk) disable iff (rst)
        wc.step && !wc.clear |=> check_bit_flop_reg != $past(check_bit_flop_reg))
        else $error("check bit did not toggle on step");

endmodule // twb_word_counter

// *** twb_disp_model.sv ***
// memory dispatcher model granting memory access after a programmable stall
`timescale 1ns/1ps
module twb_disp_model
    import twb_pkg::*;
#(
    parameter int unsigned WORD_W = 48
)
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              enable,
    input  wire logic              write_mode,
    input  wire logic [7:0]        stall,
    input  wire logic              memory_request,
    output logic                   memory_grant_ack,
    output logic                   memory_transfer_strobe,
    output logic                   mem_out_strobe,
    output logic [WORD_W-1:0]      mem_out_data
);
    logic [7:0]        wait_reg;
    logic              busy_reg;
    logic [WORD_W-1:0] seq_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {memory_grant_ack, memory_transfer_strobe, mem_out_strobe, busy_reg} <= 4'h0;
            wait_reg     <= 8'h00;
            seq_reg      <= 48'h5a0000000001;
            mem_out_data <= 48'h0;
        end else begin
            {memory_grant_ack, memory_transfer_strobe, mem_out_strobe} <= 3'h0;
            // idle data bus keeps changing
            mem_out_data <= ~mem_out_data;
            if (busy_reg && !memory_request) begin
                busy_reg <= 1'b0;
            end else if (enable && memory_request && !busy_reg) begin
                if (wait_reg == stall) begin
                    memory_grant_ack       <= 1'b1;
                    memory_transfer_strobe <= 1'b1;
                    mem_out_strobe         <= write_mode;
                    mem_out_data           <= seq_reg;
                    seq_reg                <= seq_reg + 48'h1;
                    busy_reg               <= 1'b1;
                    wait_reg               <= 8'h00;
                end else begin
                    wait_reg <= wait_reg + 8'h01;
                end
            end
        end
    end
endmodule // twb_disp_model

// *** tb_top.sv ***
// self checking bench for the tape word buffer controller
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
    import twb_pkg::*;
    logic clk = 0, rst = 1, op_start = 0, op_end = 0, wr_use = 0, rd_use = 0, cr_mode = 0, dstep = 0;
    logic fl = 0, sl = 0, cont = 1, tenth = 0, cclr = 0, dclr = 0, tstb = 0, en = 1;
    logic [47:0] tdata = 0;
    logic [31:0] seed = 32'h2be68680;
    logic ack, bstb, mstb, req, role, wep, oep, ovd, perr, wcd, avail, c1, c10;
    logic [47:0] mdat, min_d, tout_d, wq[$];
    logic [6:0] dec;
    twb_phase_e ph;
    int error_cnt = 0, checks = 0, we_cnt = 0, oe_cnt = 0, cnt = 10;

    twb_disp_model i_twb_disp_model (.clk(clk), .rst(rst), .enable(en), .write_mode(wr_use),
        .stall(8'h04 + {4'h0, seed[3:0]}), .memory_request(req), .memory_grant_ack(ack),
        .memory_transfer_strobe(bstb), .mem_out_strobe(mstb), .mem_out_data(mdat));
    twb_ctrl i_twb_ctrl (.clk(clk), .rst(rst), .op_start_pulse(op_start), .op_end_pulse(op_end),
        .write_circuits_in_use(wr_use), .read_circuits_in_use(rd_use), .check_read_mode(cr_mode),
        .digit_step_pulse(dstep), .first_word_load_pulse(fl), .second_word_load_pulse(sl),
        .continue_flag(cont), .tenth_word_transferred(tenth), .counter_clear_pulse(cclr),
        .memory_grant_ack(ack), .memory_transfer_strobe(bstb), .diag_clear(dclr),
        .tape_in_strobe(tstb), .tape_in_data(tdata), .mem_out_strobe(mstb), .mem_out_data(mdat),
        .memory_request(req), .role_select(role), .word_end_pulse(wep), .overflow_error_pulse(oep),
        .overflow_diag(ovd), .word_count_parity_error(perr), .word_counter_diag(wcd),
        .circuits_available(avail), .word_count_decode(dec), .count_one_decode(c1),
        .count_ten_decode(c10), .mem_in_data(min_d), .tape_out_data(tout_d), .write_phase(ph));

    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (wep === 1'b1) we_cnt++;
        if (oep === 1'b1) oe_cnt++;
        if (mstb === 1'b1) wq.push_back(mdat);
    end

    function automatic logic [6:0] exp_dec(input int c);
        return (c < 4) ? 7'h01 << (c - 1) : (c > 6) ? 7'h01 << (c - 4) : 7'h00;
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk_cnt();
        `CHK(dec, exp_dec(cnt))
        `CHK({c1, c10}, {cnt == 1, cnt == 10})
    endtask
    task automatic word_end();
        int n0;
        n0 = we_cnt;
        repeat (12) begin
            @(negedge clk) dstep = 1'b1;
            @(negedge clk) dstep = 1'b0;
        end
        repeat (3) @(negedge clk);
        `CHK(we_cnt, n0 + 1)
    endtask
    task automatic wait_idle();
        int k;
        for (k = 0; k < 400 && req !== 1'b0; k++) @(negedge clk);
        if (k == 400) begin
            error_cnt++;
            give_verdict();
        end
        repeat (3) @(negedge clk);
    endtask
    task automatic start_op();
        @(negedge clk) {op_start, cclr} = 2'b11;
        @(negedge clk) {op_start, cclr} = 2'b00;
        cnt = 10;
        `CHK({role, avail}, 2'b10)
    endtask

    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        `CHK({req, role, avail, ovd, wcd, dec}, {5'b01100, WC_DEC_RST})
        rd_use = 1'b1;
        start_op();
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            @(negedge clk) {tstb, tdata} = {1'b1, seed, ~seed[15:0]};
            @(negedge clk) tstb = 1'b0;
            word_end();
            `CHK({req, role}, {1'b1, i[0]})
            `CHK(min_d, {seed, ~seed[15:0]})
            wait_idle();
            cnt = cnt % 10 + 1;
            chk_cnt();
            `CHK({perr, wcd}, 2'b00)
        end
        $display("test read done");
        en = 1'b0;
        word_end();
        word_end();
        `CHK(ovd, 1'b1)
        `CHK(oe_cnt, 1)
        en = 1'b1;
        wait_idle();
        cnt = cnt % 10 + 1;
        @(negedge clk) dclr = 1'b1;
        @(negedge clk) dclr = 1'b0;
        `CHK(ovd, 1'b0)
        $display("test overflow done");
        cr_mode = 1'b1;
        word_end();
        `CHK(req, 1'b0)
        repeat (90) @(negedge clk);
        chk_cnt();
        repeat (15) @(negedge clk);
        cnt = cnt % 10 + 1;
        chk_cnt();
        {cr_mode, rd_use, wr_use} = 3'b001;
        $display("test check read done");
        start_op();
        @(negedge clk) fl = 1'b1;
        @(negedge clk) fl = 1'b0;
        `CHK({req, role, ph}, {2'b10, TWB_PRE1})
        wait_idle();
        cnt = 1;
        chk_cnt();
        @(negedge clk) sl = 1'b1;
        @(negedge clk) sl = 1'b0;
        `CHK({req, role, ph}, {2'b11, TWB_PRE2})
        wait_idle();
        cnt = 2;
        chk_cnt();
        `CHK(tout_d, wq[0])
        for (int i = 0; i < 8; i++) begin
            word_end();
            wait_idle();
            cnt++;
            chk_cnt();
        end
        {cont, tenth} = 2'b01;
        word_end();
        `CHK(req, 1'b0)
        word_end();
        `CHK({req, role, ovd, ph}, {3'b010, TWB_RUN})
        chk_cnt();
        @(negedge clk) op_end = 1'b1;
        @(negedge clk) op_end = 1'b0;
        `CHK({avail, ph}, {1'b1, TWB_IDLE})
        $display("test write done");
        give_verdict();
    end
endmodule // tb_top
